// *** rtl/cvs_pkg.sv ***
// package: register numbers, vector offsets and field layouts for the core vector and start-up control
package cvs_pkg;
	// register numbers in the core register file
	localparam logic [7:0] REG_FLAG_SPACE = 8'hE7;
	localparam logic [7:0] REG_MODE_CTRL = 8'hEB;
	localparam logic [7:0] REG_SSP_HI = 8'hEE;
	localparam logic [7:0] REG_SSP_LO = 8'hEF;
	// vector offsets within a segment
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_DIVZERO = 16'h0002;
	localparam logic [15:0] VEC_TOPLEVEL = 16'h0004;
	localparam logic [15:0] VEC_STEP = 16'h0002;
	localparam logic [7:0] SEG_FIRST = 8'h00;
	// field positions, reset values and call decrement
	localparam int FLAG_DSPACE_BIT = 3;
	localparam int MODE_PRESC_LSB = 2;
	localparam int MODE_PRESC_W = 3;
	localparam int MODE_STACK_BIT = 7;
	localparam logic [7:0] RST_FLAG = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [15:0] RST_SSP = 16'h0000;
	localparam logic [15:0] CALL_DEC = 16'h0002;

	typedef enum logic [2:0] {
		EV_NONE, EV_DIVZERO, EV_TOPLEVEL, EV_PERIPH, EV_CALL
	} cvs_event_t;

	typedef struct packed {
		logic wr;
		logic [7:0] num;
		logic [7:0] data;
	} cvs_regwr_t;

	typedef struct packed {
		logic req;
		logic [7:0] seg;
		logic [15:0] addr;
	} cvs_fetch_t;
endpackage

// *** rtl/cvs_core_vector_ctrl.sv ***
// module: vector address generation, start-up control registers and stack pointer
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - after reset the start address is fetched from word 0 of segment 0
// - pin, watchdog and software resets all use the same start vector
// - divide by zero traps through offset 2 of the executing segment
// - other interrupt vectors come from the interrupt segment
// - top-level interrupt uses offset 4 of the interrupt segment
// - peripheral cause k is fetched at base n plus 2k
// - in extended mode interrupt routines may far call other segments
// - prescaler field zero runs the core from the undivided clock
// - in legacy mode data-space bit clear selects program, set selects data memory
// - data-space bit changes only by set-data and set-program instructions
// - system stack pointer is a 16-bit pair at registers 238 and 239
// - a call decrements the stack pointer by two, then writes return address
module cvs_core_vector_ctrl (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic pinResetReq,
	input wire logic wdgResetReq,
	input wire logic swResetReq,
	input wire logic extendedMode,
	input wire cvs_pkg::cvs_regwr_t regWrite,
	input wire logic [7:0] regReadNum,
	input wire logic setDataMemInstr,
	input wire logic setProgMemInstr,
	input wire cvs_pkg::cvs_event_t eventKind,
	input wire logic [7:0] currentSegment,
	input wire logic [7:0] interruptSegment,
	input wire logic [15:0] periphVectorBase,
	input wire logic [3:0] periphCause,
	input wire logic farCallReq,
	input wire logic [7:0] farCallSegment,
	input wire logic [15:0] returnAddr,
	output cvs_pkg::cvs_fetch_t vectorFetch,
	output logic [7:0] farCallTarget,
	output logic farCallAllowed,
	output logic [7:0] regReadData,
	output logic dataSpaceSel,
	output logic [cvs_pkg::MODE_PRESC_W-1:0] prescaler,
	output logic fullSpeed,
	output logic stackInMemory,
	output logic [15:0] systemStackPointer,
	output logic stackWriteEn,
	output logic [15:0] stackWriteAddr,
	output logic [15:0] stackWriteData
);
	import cvs_pkg::*;

	logic [7:0] flagReg, flagNext;
	logic [7:0] modeReg, modeNext;
	logic [15:0] sspReg, sspNext;
	logic anyReset;
	logic bootPending_reg;
	logic callPhase_reg;
	logic [15:0] callAddr_reg;
	logic [15:0] callData_reg;

	function automatic logic [15:0] periph_vec(input logic [15:0] base, input logic [3:0] cause);
		periph_vec = base + {11'h000, cause, 1'b0};
	endfunction

	// ==========================================
	// reset sources and boot fetch
	assign anyReset = pinResetReq | wdgResetReq | swResetReq;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bootPending_reg <= 1'b1;
		end else begin
			bootPending_reg <= anyReset;
		end
	end

	// ==========================================
	// vector address generation
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			vectorFetch <= '0;
		end else if (bootPending_reg || anyReset) begin
			vectorFetch <= '{req: 1'b1, seg: SEG_FIRST, addr: VEC_RESET};
		end else begin
			case (eventKind)
				EV_DIVZERO: begin
					vectorFetch <= '{req: 1'b1, seg: currentSegment, addr: VEC_DIVZERO};
				end
				EV_TOPLEVEL: begin
					vectorFetch <= '{req: 1'b1, seg: interruptSegment, addr: VEC_TOPLEVEL};
				end
				EV_PERIPH: begin
					vectorFetch <= '{req: 1'b1, seg: interruptSegment,
						addr: periph_vec(periphVectorBase, periphCause)};
				end
				default: begin
					vectorFetch <= '{req: 1'b0, seg: vectorFetch.seg, addr: vectorFetch.addr};
				end
			endcase
		end
	end

	// far calls out of the interrupt segment only in extended mode
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			farCallAllowed <= 1'b0;
			farCallTarget <= 8'h00;
		end else begin
			farCallAllowed <= farCallReq & (extendedMode | (farCallSegment == interruptSegment));
			farCallTarget <= farCallSegment;
		end
	end

	// ==========================================
	// control registers
	always_comb begin
		flagNext = flagReg;
		if (setDataMemInstr)
			flagNext[FLAG_DSPACE_BIT] = 1'b1;
		else if (setProgMemInstr && !extendedMode)
			flagNext[FLAG_DSPACE_BIT] = 1'b0;
		if (regWrite.wr && regWrite.num == REG_FLAG_SPACE)
			flagNext = {regWrite.data[7:FLAG_DSPACE_BIT+1], flagNext[FLAG_DSPACE_BIT],
				regWrite.data[FLAG_DSPACE_BIT-1:0]};
	end

	always_comb begin
		modeNext = modeReg;
		if (regWrite.wr && regWrite.num == REG_MODE_CTRL)
			modeNext = regWrite.data;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flagReg <= RST_FLAG;
			modeReg <= RST_MODE;
		end else begin
			flagReg <= flagNext;
			modeReg <= modeNext;
		end
	end

	assign dataSpaceSel = flagReg[FLAG_DSPACE_BIT];
	assign prescaler = modeReg[MODE_PRESC_LSB +: MODE_PRESC_W];
	assign fullSpeed = (prescaler == '0);
	assign stackInMemory = modeReg[MODE_STACK_BIT];

	// ==========================================
	// system stack pointer and call push
	always_comb begin
		sspNext = sspReg;
		if (regWrite.wr && regWrite.num == REG_SSP_HI)
			sspNext[15:8] = regWrite.data;
		if (regWrite.wr && regWrite.num == REG_SSP_LO)
			sspNext[7:0] = regWrite.data;
		if (eventKind == EV_CALL)
			sspNext = sspReg - CALL_DEC;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sspReg <= RST_SSP;
			callPhase_reg <= 1'b0;
			callAddr_reg <= 16'h0000;
			callData_reg <= 16'h0000;
		end else begin
			sspReg <= sspNext;
			callPhase_reg <= (eventKind == EV_CALL);
			callAddr_reg <= sspNext;
			callData_reg <= returnAddr;
		end
	end

	assign systemStackPointer = sspReg;
	assign stackWriteEn = callPhase_reg;
	assign stackWriteAddr = callAddr_reg;
	assign stackWriteData = callData_reg;

	// ==========================================
	// register readback
	always_comb begin
		case (regReadNum)
			REG_FLAG_SPACE: regReadData = flagReg;
			REG_MODE_CTRL: regReadData = modeReg;
			REG_SSP_HI: regReadData = sspReg[15:8];
			REG_SSP_LO: regReadData = sspReg[7:0];
			default: regReadData = 8'h00;
		endcase
	end

	// ==========================================
	// checks
	a_reset_vector: assert property (@(posedge clock) disable iff (!arst_n)
		anyReset |=> vectorFetch.req && vectorFetch.seg == SEG_FIRST && vectorFetch.addr == VEC_RESET)
		else $error("reset did not fetch word 0 of segment 0");
	a_same_start: assert property (@(posedge clock) disable iff (!arst_n)
		(wdgResetReq || swResetReq) |=> vectorFetch.addr == VEC_RESET)
		else $error("reset sources differ in start vector");
	a_divzero_vector: assert property (@(posedge clock) disable iff (!arst_n)
		(!anyReset && !bootPending_reg && eventKind == EV_DIVZERO) |=>
		vectorFetch.seg == $past(currentSegment) && vectorFetch.addr == VEC_DIVZERO)
		else $error("divide trap vector wrong");
	a_toplevel_vector: assert property (@(posedge clock) disable iff (!arst_n)
		(!anyReset && !bootPending_reg && eventKind == EV_TOPLEVEL) |=>
		vectorFetch.seg == $past(interruptSegment) && vectorFetch.addr == VEC_TOPLEVEL)
		else $error("top-level vector wrong");
	a_periph_vector: assert property (@(posedge clock) disable iff (!arst_n)
		(!anyReset && !bootPending_reg && eventKind == EV_PERIPH) |=>
		vectorFetch.addr == $past(periphVectorBase) + {11'h000, $past(periphCause), 1'b0})
		else $error("peripheral vector step wrong");
	a_far_call: assert property (@(posedge clock) disable iff (!arst_n)
		(farCallReq && extendedMode) |=> farCallAllowed)
		else $error("far call refused in extended mode");
	a_full_speed: assert property (@(posedge clock) disable iff (!arst_n)
		(regWrite.wr && regWrite.num == REG_MODE_CTRL) |=>
		fullSpeed == ($past(regWrite.data[MODE_PRESC_LSB +: MODE_PRESC_W]) == '0))
		else $error("zero prescaler not full speed");
	a_space_stable: assert property (@(posedge clock) disable iff (!arst_n)
		(!setDataMemInstr && !setProgMemInstr) |=> $stable(dataSpaceSel))
		else $error("data-space bit changed without instruction");
	a_call_push: assert property (@(posedge clock) disable iff (!arst_n)
		(eventKind == EV_CALL && !regWrite.wr) |=>
		stackWriteEn && systemStackPointer == $past(sspReg) - CALL_DEC && stackWriteAddr == systemStackPointer)
		else $error("call push order wrong");
endmodule
`default_nettype wire

// *** tb/cvs_prog_mem.sv ***
// program memory model answering vector fetches
`timescale 1ns/1ps
`default_nettype none
module cvs_prog_mem (
	input wire logic clock,
	input wire cvs_pkg::cvs_fetch_t vectorFetch,
	output logic [15:0] fetchedWord
);
	import cvs_pkg::*;
	initial fetchedWord = 16'h0000;
	// table word built from segment and offset; idle bus toggles
	always @(posedge clock) begin
		if (vectorFetch.req) begin
			fetchedWord <= {vectorFetch.seg, vectorFetch.addr[7:0]} ^ 16'h5A5A;
		end else begin
			fetchedWord <= ~fetchedWord;
		end
	end
endmodule
`default_nettype wire

// *** tb/cvs_core_vector_ctrl_tb.sv ***
// self-checking bench for vector generation and start-up registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t %h %h", $time, g, e); end end
module cvs_core_vector_ctrl_tb;
	import cvs_pkg::*;
	logic clock = 1'b0, arst_n = 1'b0, extMode = 1'b0, setD = 1'b0, setP = 1'b0, fcReq = 1'b0;
	logic [2:0] rst = 3'h0;
	cvs_regwr_t regWrite = '0;
	cvs_event_t eventKind = EV_NONE;
	logic [7:0] readNum = 8'h00, curSeg = 8'h00, intSeg = 8'h00, fcSeg = 8'h00;
	logic [15:0] base = 16'h0000, retAddr = 16'h0000, word, system_stack_pointer, swAddr, swData;
	logic [3:0] cause = 4'h0;
	cvs_fetch_t vf;
	logic [7:0] fcTarget, rdData;
	logic [2:0] presc;
	logic fcAllowed, dSel, fullSpd, stkMem, swEn;
	int mismatches = 0, comparisons = 0, seed = 50912;
	cvs_core_vector_ctrl i_cvs_core_vector_ctrl (.clock(clock), .arst_n(arst_n), .pinResetReq(rst[0]),
		.wdgResetReq(rst[1]), .swResetReq(rst[2]), .extendedMode(extMode), .regWrite(regWrite),
		.regReadNum(readNum), .setDataMemInstr(setD), .setProgMemInstr(setP), .eventKind(eventKind),
		.currentSegment(curSeg), .interruptSegment(intSeg), .periphVectorBase(base), .periphCause(cause),
		.farCallReq(fcReq), .farCallSegment(fcSeg), .returnAddr(retAddr), .vectorFetch(vf),
		.farCallTarget(fcTarget), .farCallAllowed(fcAllowed), .regReadData(rdData), .dataSpaceSel(dSel),
		.prescaler(presc), .fullSpeed(fullSpd), .stackInMemory(stkMem), .systemStackPointer(system_stack_pointer),
		.stackWriteEn(swEn), .stackWriteAddr(swAddr), .stackWriteData(swData));
	cvs_prog_mem i_cvs_prog_mem (.clock(clock), .vectorFetch(vf), .fetchedWord(word));
	initial forever #12.5 clock = ~clock;
	task automatic print_verdict();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] n, input logic [7:0] d);
		@(posedge clock);
		regWrite <= '{wr: 1'b1, num: n, data: d};
		@(posedge clock);
		regWrite <= '0;
		#1;
	endtask
	task automatic ev(input cvs_event_t k);
		@(posedge clock);
		eventKind <= k;
		curSeg <= $random(seed);
		intSeg <= $random(seed);
		base <= $random(seed) & 16'hFFF8;
		cause <= $random(seed);
		retAddr <= $random(seed);
		@(posedge clock);
		eventKind <= EV_NONE;
		#1;
	endtask
	task automatic pulse(input logic d, input logic p);
		@(posedge clock);
		setD <= d;
		setP <= p;
		@(posedge clock);
		setD <= 1'b0;
		setP <= 1'b0;
		#1;
	endtask
	initial begin
		#100us;
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		#1 `CHK(vf, {1'b1, SEG_FIRST, VEC_RESET})
		@(posedge clock);
		#1 `CHK(word, 16'h5A5A)
		// a pending trap must lose against every reset source
		for (int i = 0; i < 3; i++) begin
			@(posedge clock);
			rst <= 3'h1 << i;
			eventKind <= EV_DIVZERO;
			curSeg <= 8'h3C;
			@(posedge clock);
			rst <= 3'h0;
			eventKind <= EV_NONE;
			#1 `CHK(vf, {1'b1, SEG_FIRST, VEC_RESET})
			repeat (2) @(posedge clock);
		end
		// mode and stack pointer are loaded before any interrupt or call
		wreg(REG_MODE_CTRL, 8'h80);
		`CHK({presc, fullSpd, stkMem}, 5'h03)
		wreg(REG_MODE_CTRL, 8'h0C);
		`CHK({presc, fullSpd}, 4'h6)
		wreg(REG_SSP_HI, 8'h01);
		wreg(REG_SSP_LO, 8'h40);
		@(posedge clock);
		readNum <= REG_SSP_HI;
		#1 `CHK({rdData, system_stack_pointer}, 24'h010140)
		@(posedge clock);
		readNum <= REG_SSP_LO;
		#1 `CHK(rdData, 8'h40)
		@(posedge clock);
		readNum <= REG_MODE_CTRL;
		#1 `CHK(rdData, 8'h0C)
		for (int i = 0; i < 30; i++) begin
			ev(cvs_event_t'(i % 3 + 1));
			if (i % 3 == 0) `CHK(vf, {1'b1, curSeg, VEC_DIVZERO})
			if (i % 3 == 1) `CHK(vf, {1'b1, intSeg, VEC_TOPLEVEL})
			if (i % 3 == 2) `CHK(vf, {1'b1, intSeg, base + 16'(cause) * 16'h0002})
		end
		ev(EV_CALL);
		`CHK({system_stack_pointer, swEn, swAddr, swData}, {16'h013E, 1'b1, 16'h013E, retAddr})
		pulse(1'b1, 1'b0);
		`CHK(dSel, 1'b1)
		pulse(1'b0, 1'b1);
		`CHK(dSel, 1'b0)
		wreg(REG_FLAG_SPACE, 8'hFF);
		`CHK(dSel, 1'b0)
		@(posedge clock);
		readNum <= REG_FLAG_SPACE;
		#1 `CHK(rdData, 8'hF7)
		// extended mode: data space set once, program space never selected
		@(posedge clock);
		extMode <= 1'b1;
		pulse(1'b1, 1'b0);
		repeat (4) @(posedge clock);
		#1 `CHK(dSel, 1'b1)
		@(posedge clock);
		fcReq <= 1'b1;
		fcSeg <= intSeg + 8'h01;
		@(posedge clock);
		fcReq <= 1'b0;
		#1 `CHK({fcAllowed, fcTarget}, {1'b1, fcSeg})
		// legacy mode keeps far calls inside the interrupt segment
		@(posedge clock);
		extMode <= 1'b0;
		fcReq <= 1'b1;
		@(posedge clock);
		fcReq <= 1'b0;
		#1 `CHK({fcAllowed, fcTarget}, {1'b0, fcSeg})
		@(posedge clock);
		fcReq <= 1'b1;
		fcSeg <= intSeg;
		@(posedge clock);
		fcReq <= 1'b0;
		#1 `CHK({fcAllowed, fcTarget}, {1'b1, intSeg})
		// second reset in mid-run: registers clear, boot fetch follows release
		@(posedge clock);
		arst_n <= 1'b0;
		@(posedge clock);
		#1 `CHK({vf, system_stack_pointer, dSel, presc, swEn, fcAllowed}, 47'h0)
		@(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		#1 `CHK(vf, {1'b1, SEG_FIRST, VEC_RESET})
		print_verdict();
	end
endmodule
`default_nettype wire
